// ===== bst_pkg.sv
package bst_pkg;

    // Widths
    localparam int BST_IR_W = 10;
    localparam int BST_ID_W = 32;
    localparam int BST_PINS = 4;
    localparam int BST_CELLS = 3;
    localparam int BST_BSR_W = BST_PINS * BST_CELLS;

    // Cell positions inside one pin's group of boundary cells
    localparam int BST_CELL_IN = 0;
    localparam int BST_CELL_OE = 1;
    localparam int BST_CELL_OUT = 2;

    // Instruction opcodes; all ones is fixed, the rest may be reassigned
    localparam logic [BST_IR_W-1:0] BST_OP_BYPASS = 10'h3ff;
    localparam logic [BST_IR_W-1:0] BST_OP_SAMPLE = 10'h005;
    localparam logic [BST_IR_W-1:0] BST_OP_EXTEST = 10'h00f;
    localparam logic [BST_IR_W-1:0] BST_OP_IDCODE = 10'h006;
    localparam logic [BST_IR_W-1:0] BST_OP_USERCODE = 10'h007;
    localparam logic [BST_IR_W-1:0] BST_OP_CLAMP = 10'h00a;
    localparam logic [BST_IR_W-1:0] BST_OP_HIGHZ = 10'h00b;

    // Identification code; value is arbitrary, bit 0 set as the standard asks
    localparam logic [BST_ID_W-1:0] BST_ID_DEFAULT = 32'h0000_0001;

    // Value loaded into the bypass cell at capture
    localparam logic BST_BYP_CAPTURE = 1'b0;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
        TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
        TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
    } bst_tap_t;

    // Functional signals from the core, one bit per pin
    typedef struct packed {
        logic [BST_PINS-1:0] out;
        logic [BST_PINS-1:0] oe;
    } bst_core_t;

    // State handed from the test-clock side to the system-clock side
    typedef struct packed {
        logic extest;
        logic clamp;
        logic highz;
        logic [BST_PINS-1:0] updOut;
        logic [BST_PINS-1:0] updOe;
    } bst_pub_t;

    localparam bst_pub_t BST_PUB_RESET = '0;

endpackage : bst_pkg

// ===== bst_tap_ctrl.sv
// Functional notes
// - Instructions are ten bits and the instruction register holds exactly ten.
// - Standard sixteen-state controller advancing on rising test clock per mode-select.
// - In test-logic-reset, scan logic inactive, normal operation, identification instruction loaded.
// - Controller starts in test-logic-reset at power up; no test reset pin.
// - Five clocks with mode-select high reach test-logic-reset from anywhere.
// - Controller stays in test-logic-reset while mode-select stays high.
// - Data output is high impedance except in Shift-IR and Shift-DR.
// - Output driver switches on and off at falling edges after shift entry/exit.
// - Shift-IR drives the existing instruction contents out on falling edges.
// - Shift-IR holds while mode-select low, taking one data bit per rising edge.
// - Sample capture takes live pin and core signals; pins keep functional data.
// - Boundary Shift-DR moves captured data out while new data enters behind.
// - Boundary update copies shifted capture contents into the update registers.
// - Two rising edges with mode-select high take Shift-DR to Update-DR.
// - With global enable deasserted, sample captures core output enables, not high-Z.
// - Under extest, pins are driven from the update registers, not the core.
// - Under extest, capture records resulting pin levels for the next shift.
// - An all-ones instruction selects bypass.
// - Bypass takes data in on rising edge, presents it on the falling edge.
// - Identification instruction loads the fixed 32-bit code for shifting.
// - Bypass register is one bit, the shortest serial path.
// - User-code instruction loads the 32-bit user signature for shifting.
// - Clamp drives pins from boundary contents while bypass is the serial path.
// - High-impedance instruction releases all user pins and selects bypass.
module bst_tap_ctrl
    import bst_pkg::*;
#(
    parameter logic [BST_ID_W-1:0] ID_CODE = BST_ID_DEFAULT
) (
    // System clock and power-on reset
    input wire logic clk,
    input wire logic nrst,
    // Core side
    input wire bst_core_t coreIn,
    input wire logic [BST_ID_W-1:0] userCode,
    // User pins
    input wire logic [BST_PINS-1:0] pinIn,
    output logic [BST_PINS-1:0] pinOut,
    output logic [BST_PINS-1:0] pinOeN,
    input wire logic globalOutputEnablePin,
    // Test access port
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdoOeN
);

    localparam int SRC_W = BST_ID_W + 3 * BST_PINS;

    // ---------------- Test clock domain ----------------
    logic [1:0] tckRst_r;
    logic tckRstN;
    bst_tap_t state_r;
    bst_tap_t state_nxt;
    logic [BST_IR_W-1:0] instr_r;
    logic [BST_IR_W-1:0] irShift_r;
    logic [BST_BSR_W-1:0] bsr_r;
    logic [BST_BSR_W-1:0] bsrCap;
    logic [BST_PINS-1:0] bsrOut;
    logic [BST_PINS-1:0] bsrOe;
    logic [BST_PINS-1:0] updOut_r;
    logic [BST_PINS-1:0] updOe_r;
    logic [BST_ID_W-1:0] id_r;
    logic byp_r;
    logic [SRC_W-1:0] srcA_r;
    logic [SRC_W-1:0] srcB_r;
    logic [BST_PINS-1:0] pinSync;
    logic [BST_PINS-1:0] coreOutSync;
    logic [BST_PINS-1:0] coreOeSync;
    logic [BST_ID_W-1:0] userSync;
    logic selBsr;
    logic selId;
    logic selByp;
    logic isExtest;
    logic shiftIr;
    logic shiftDr;
    bst_pub_t pubNow;
    bst_pub_t pub_r;
    logic pubTgl_r;
    logic tdo_r;
    logic tdoOeN_r;

    // Reset released on tck so the controller never leaves reset mid-edge
    always_ff @(posedge tck or negedge nrst) begin
        if (!nrst) begin
            tckRst_r <= 2'h0;
        end else begin
            tckRst_r <= {tckRst_r[0], 1'b1};
        end
    end
    assign tckRstN = tckRst_r[1];

    function automatic bst_tap_t tapNext(input bst_tap_t s, input logic m);
        unique case (s)
            TAP_RESET: tapNext = m ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: tapNext = m ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_SHIFT_DR: tapNext = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
            TAP_EXIT1_DR: tapNext = m ? TAP_UPD_DR : TAP_PAUSE_DR;
            TAP_PAUSE_DR: tapNext = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
            TAP_EXIT2_DR: tapNext = m ? TAP_UPD_DR : TAP_SHIFT_DR;
            TAP_UPD_DR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: tapNext = m ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_SHIFT_IR: tapNext = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
            TAP_EXIT1_IR: tapNext = m ? TAP_UPD_IR : TAP_PAUSE_IR;
            TAP_PAUSE_IR: tapNext = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
            TAP_EXIT2_IR: tapNext = m ? TAP_UPD_IR : TAP_SHIFT_IR;
            TAP_UPD_IR: tapNext = m ? TAP_SEL_DR : TAP_IDLE;
        endcase
    endfunction : tapNext

    assign state_nxt = tapNext(state_r, tms);

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            state_r <= TAP_RESET;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign shiftIr = (state_r == TAP_SHIFT_IR);
    assign shiftDr = (state_r == TAP_SHIFT_DR);

    // Pin and core levels cross into tck before capture
    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            srcA_r <= '0;
            srcB_r <= '0;
        end else begin
            srcA_r <= {userCode, coreIn.oe, coreIn.out, pinIn};
            srcB_r <= srcA_r;
        end
    end
    assign {userSync, coreOeSync, coreOutSync, pinSync} = srcB_r;

    // Instruction register
    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            instr_r <= BST_OP_IDCODE;
        end else if (state_nxt == TAP_RESET) begin
            instr_r <= BST_OP_IDCODE;
        end else if (state_r == TAP_UPD_IR) begin
            instr_r <= irShift_r;
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            irShift_r <= BST_OP_IDCODE;
        end else if (state_r == TAP_CAP_IR) begin
            irShift_r <= instr_r;
        end else if (shiftIr) begin
            irShift_r <= {tdi, irShift_r[BST_IR_W-1:1]};
        end
    end

    // Unlisted opcodes, bypass, clamp and highz all fall to bypass
    assign selBsr = (instr_r == BST_OP_SAMPLE) || (instr_r == BST_OP_EXTEST);
    assign selId = (instr_r == BST_OP_IDCODE) || (instr_r == BST_OP_USERCODE);
    assign selByp = !selBsr && !selId;
    assign isExtest = (instr_r == BST_OP_EXTEST);

    // Boundary cells, one group of three per pin
    genvar gi;
    generate
        for (gi = 0; gi < BST_PINS; gi++) begin : g_cell
            // Core enables are captured raw, ignoring the global enable pin
            assign bsrCap[gi*BST_CELLS+BST_CELL_OE] =
                isExtest ? updOe_r[gi] : coreOeSync[gi];
            assign bsrCap[gi*BST_CELLS+BST_CELL_OUT] =
                isExtest ? updOut_r[gi] : coreOutSync[gi];
            assign bsrCap[gi*BST_CELLS+BST_CELL_IN] = pinSync[gi];
            assign bsrOut[gi] = bsr_r[gi*BST_CELLS+BST_CELL_OUT];
            assign bsrOe[gi] = bsr_r[gi*BST_CELLS+BST_CELL_OE];
        end
    endgenerate

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            bsr_r <= '0;
        end else if (selBsr && state_r == TAP_CAP_DR) begin
            bsr_r <= bsrCap;
        end else if (selBsr && shiftDr) begin
            bsr_r <= {tdi, bsr_r[BST_BSR_W-1:1]};
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            updOut_r <= '0;
            updOe_r <= '0;
        end else if (selBsr && state_r == TAP_UPD_DR) begin
            updOut_r <= bsrOut;
            updOe_r <= bsrOe;
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            id_r <= ID_CODE;
        end else if (selId && state_r == TAP_CAP_DR) begin
            id_r <= (instr_r == BST_OP_USERCODE) ? userSync : ID_CODE;
        end else if (selId && shiftDr) begin
            id_r <= {tdi, id_r[BST_ID_W-1:1]};
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            byp_r <= BST_BYP_CAPTURE;
        end else if (selByp && state_r == TAP_CAP_DR) begin
            byp_r <= BST_BYP_CAPTURE;
        end else if (selByp && shiftDr) begin
            byp_r <= tdi;
        end
    end

    // Mode and update values published with a toggle; the bundle only
    // changes together with the toggle, so the far side copies a stable word
    assign pubNow = '{extest: isExtest,
                      clamp: instr_r == BST_OP_CLAMP,
                      highz: instr_r == BST_OP_HIGHZ,
                      updOut: updOut_r,
                      updOe: updOe_r};

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            pub_r <= BST_PUB_RESET;
        end else if (pubNow != pub_r) begin
            pub_r <= pubNow;
        end
    end

    always_ff @(posedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            pubTgl_r <= 1'b0;
        end else if (pubNow != pub_r) begin
            pubTgl_r <= !pubTgl_r;
        end
    end

    // Data output changes on the falling edge only
    always_ff @(negedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            tdoOeN_r <= 1'b1;
        end else begin
            tdoOeN_r <= !(shiftIr || shiftDr);
        end
    end

    always_ff @(negedge tck or negedge tckRstN) begin
        if (!tckRstN) begin
            tdo_r <= 1'b0;
        end else if (shiftIr) begin
            tdo_r <= irShift_r[0];
        end else if (selBsr) begin
            tdo_r <= bsr_r[0];
        end else if (selId) begin
            tdo_r <= id_r[0];
        end else begin
            tdo_r <= byp_r;
        end
    end

    assign tdo = tdo_r;
    assign tdoOeN = tdoOeN_r;

    // ---------------- System clock domain ----------------
    logic [2:0] tglSync_r;
    logic [1:0] gOe_r;
    bst_pub_t pubClk_r;
    logic [BST_PINS-1:0] pinOut_r;
    logic [BST_PINS-1:0] pinOeN_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tglSync_r <= 3'h0;
            gOe_r <= 2'h0;
        end else begin
            tglSync_r <= {tglSync_r[1:0], pubTgl_r};
            gOe_r <= {gOe_r[0], globalOutputEnablePin};
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pubClk_r <= BST_PUB_RESET;
        end else if (tglSync_r[2] != tglSync_r[1]) begin
            pubClk_r <= pub_r;
        end
    end

    // Sample keeps the functional path, so pins see no interruption
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pinOut_r <= '0;
            pinOeN_r <= '1;
        end else if (pubClk_r.highz) begin
            pinOut_r <= pubClk_r.updOut;
            pinOeN_r <= '1;
        end else if (pubClk_r.extest || pubClk_r.clamp) begin
            pinOut_r <= pubClk_r.updOut;
            pinOeN_r <= ~pubClk_r.updOe;
        end else begin
            pinOut_r <= coreIn.out;
            pinOeN_r <= ~(coreIn.oe & {BST_PINS{gOe_r[1]}});
        end
    end

    assign pinOut = pinOut_r;
    assign pinOeN = pinOeN_r;

    // ---------------- Checks ----------------
    sequence s_tms_high5;
        tms [*5];
    endsequence

    sequence s_ir_entry;
        state_r == TAP_RESET && !tms ##1 tms ##1 tms ##1 !tms ##1 !tms;
    endsequence

    sequence s_dr_exit;
        shiftDr && tms ##1 tms;
    endsequence

    property p_five_ones;
        @(posedge tck) disable iff (!tckRstN) s_tms_high5 |=> state_r == TAP_RESET;
    endproperty
    a_five_ones: assert property (p_five_ones) else $error("five tms highs miss reset");

    property p_stay_reset;
        @(posedge tck) disable iff (!tckRstN)
            state_r == TAP_RESET && tms |=> state_r == TAP_RESET;
    endproperty
    a_stay_reset: assert property (p_stay_reset) else $error("left reset with tms high");

    property p_reset_idcode;
        @(posedge tck) disable iff (!tckRstN)
            state_r == TAP_RESET |-> instr_r == BST_OP_IDCODE && !pubNow.extest;
    endproperty
    a_reset_idcode: assert property (p_reset_idcode) else $error("reset lacks idcode");

    property p_ir_entry;
        @(posedge tck) disable iff (!tckRstN) s_ir_entry |=> shiftIr;
    endproperty
    a_ir_entry: assert property (p_ir_entry) else $error("01100 did not reach shift-ir");

    property p_tdo_enable;
        @(posedge tck) disable iff (!tckRstN) ##1 tdoOeN_r == !(shiftIr || shiftDr);
    endproperty
    a_tdo_enable: assert property (p_tdo_enable) else $error("tdo enable mismatch");

    property p_ir_shift;
        @(posedge tck) disable iff (!tckRstN)
            shiftIr |=> irShift_r[BST_IR_W-1] == $past(tdi)
                && irShift_r[BST_IR_W-2:0] == $past(irShift_r[BST_IR_W-1:1]);
    endproperty
    a_ir_shift: assert property (p_ir_shift) else $error("ir shift wrong");

    property p_update_ir;
        @(posedge tck) disable iff (!tckRstN)
            state_r == TAP_UPD_IR && !tms |=> instr_r == $past(irShift_r);
    endproperty
    a_update_ir: assert property (p_update_ir) else $error("instruction not updated");

    property p_bypass;
        @(posedge tck) disable iff (!tckRstN)
            shiftDr && selByp && !tms |=> byp_r == $past(tdi) && tdo_r == byp_r;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass path wrong");

    property p_dr_exit;
        @(posedge tck) disable iff (!tckRstN) s_dr_exit |=> state_r == TAP_UPD_DR;
    endproperty
    a_dr_exit: assert property (p_dr_exit) else $error("two highs miss update-dr");

    property p_bsr_shift;
        @(posedge tck) disable iff (!tckRstN)
            shiftDr && selBsr |=> bsr_r[BST_BSR_W-1] == $past(tdi)
                && bsr_r[BST_BSR_W-2:0] == $past(bsr_r[BST_BSR_W-1:1]);
    endproperty
    a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");

    property p_update_dr;
        @(posedge tck) disable iff (!tckRstN)
            state_r == TAP_UPD_DR && selBsr |=> updOut_r == $past(bsrOut)
                && updOe_r == $past(bsrOe);
    endproperty
    a_update_dr: assert property (p_update_dr) else $error("update regs not loaded");

    property p_id_capture;
        @(posedge tck) disable iff (!tckRstN)
            state_r == TAP_CAP_DR && instr_r == BST_OP_IDCODE |=> id_r == ID_CODE;
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("idcode not loaded");

    property p_highz;
        @(posedge clk) disable iff (!nrst) pubClk_r.highz |=> pinOeN_r == '1;
    endproperty
    a_highz: assert property (p_highz) else $error("pins driven under highz");

    property p_extest_drive;
        @(posedge clk) disable iff (!nrst)
            pubClk_r.extest && !pubClk_r.highz |=> pinOut_r == $past(pubClk_r.updOut)
                && pinOeN_r == ~$past(pubClk_r.updOe);
    endproperty
    a_extest_drive: assert property (p_extest_drive) else $error("extest pins wrong");

endmodule : bst_tap_ctrl

// ===== bst_tester.sv
module bst_tester (
    // Test access port, tester side
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdoOeN
);
    timeunit 1ns;
    timeprecision 1ps;

    // Test clock stands low between frames, as the pull-down would hold it
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end

    // One 49 ns test clock cycle; tdo is taken once the falling edge has landed
    task automatic cyc(input logic m, input logic d, output logic o, output logic oeN);
        tms = m;
        tdi = d;
        #24 tck = 1'b1;
        #24 tck = 1'b0;
        #1;
        o = tdo;
        oeN = tdoOeN;
    endtask : cyc

    // Released lines go to their pull-up level
    task automatic rest();
        #1;
        tms = 1'b1;
        tdi = 1'b1;
    endtask : rest
endmodule : bst_tester

// ===== boundary_scan_tap_control_tb.sv
module boundary_scan_tap_control_tb import bst_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    // Arbitrary identification value
    localparam logic [BST_ID_W-1:0] ID_VAL = 32'h2b5c_9e31;
    localparam logic [9:0] OPS [8] = '{BST_OP_SAMPLE, BST_OP_EXTEST, BST_OP_CLAMP,
        BST_OP_HIGHZ, BST_OP_USERCODE, BST_OP_BYPASS, 10'h155, BST_OP_IDCODE};
    logic clk, nrst, gOe, tck, tms, tdi, tdo, tdoOeN;
    bst_core_t coreIn;
    logic [31:0] userCode, lfsr, sr;
    logic [3:0] extPin, pinIn, pinOut, pinOeN;
    logic [9:0] ins;
    logic [11:0] upd;
    logic [39:0] v;
    bst_tap_t st;
    int len, badCount, cmpCount;

    bst_tap_ctrl #(.ID_CODE(ID_VAL)) bst_tap_ctrl_inst (.clk(clk), .nrst(nrst),
        .coreIn(coreIn), .userCode(userCode), .pinIn(pinIn), .pinOut(pinOut),
        .pinOeN(pinOeN), .globalOutputEnablePin(gOe), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdoOeN(tdoOeN));
    bst_tester bst_tester_inst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdoOeN(tdoOeN));

    // Pads read back their own drive, else the board level
    always_comb for (int i = 0; i < 4; i++) pinIn[i] = pinOeN[i] ? extPin[i] : pinOut[i];

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #400000;
        badCount++;
        closeOut();
    end

    function automatic logic rb();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[0];
    endfunction : rb

    task automatic cmpBit(input logic g, input logic e);
        cmpCount++;
        if (g !== e) begin
            badCount++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : cmpBit

    task automatic cmpPins(input logic [7:0] g, input logic [7:0] e);
        cmpCount++;
        if (g !== e) begin
            badCount++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask : cmpPins

    // Undriven pins are masked to 0 in the data half
    function automatic logic [7:0] expPins();
        logic [3:0] o, n;
        o = coreIn.out;
        n = ~(coreIn.oe & {4{gOe}});
        if (ins == BST_OP_EXTEST || ins == BST_OP_CLAMP) begin
            for (int i = 0; i < 4; i++) begin
                o[i] = upd[3*i+2];
                n[i] = ~upd[3*i+1];
            end
        end
        if (ins == BST_OP_HIGHZ) n = 4'hf;
        return {o & ~n, n};
    endfunction : expPins

    // Relies on the package's state order: select, capture, shift, exit1, pause, exit2, update
    function automatic bst_tap_t nxt(bst_tap_t s, logic m);
        int b, r;
        if (s == TAP_RESET) return m ? TAP_RESET : TAP_IDLE;
        if (s == TAP_IDLE) return m ? TAP_SEL_DR : TAP_IDLE;
        b = (s >= TAP_SEL_IR) ? 9 : 2;
        case (int'(s) - b)
            0: r = m ? ((b == 2) ? 9 : 0) : b + 1;
            1, 2: r = m ? b + 3 : b + 2;
            3: r = m ? b + 6 : b + 4;
            4: r = m ? b + 5 : b + 4;
            5: r = m ? b + 6 : b + 2;
            default: r = m ? 2 : 1;
        endcase
        return bst_tap_t'(r);
    endfunction : nxt

    task automatic capDr();
        logic [7:0] p;
        p = expPins();
        sr = {31'h0, BST_BYP_CAPTURE};
        len = 1;
        if (ins == BST_OP_IDCODE) begin
            sr = ID_VAL;
            len = 32;
        end
        if (ins == BST_OP_USERCODE) begin
            sr = userCode;
            len = 32;
        end
        if (ins == BST_OP_SAMPLE || ins == BST_OP_EXTEST) begin
            len = 12;
            for (int i = 0; i < 4; i++) begin
                sr[3*i] = p[i] ? extPin[i] : p[i+4];
                sr[3*i+1] = (ins == BST_OP_SAMPLE) ? coreIn.oe[i] : upd[3*i+1];
                sr[3*i+2] = (ins == BST_OP_SAMPLE) ? coreIn.out[i] : upd[3*i+2];
            end
        end
    endtask : capDr

    task automatic tc(input logic m, input logic d);
        logic o, oeN, sh;
        bst_tester_inst.cyc(m, d, o, oeN);
        if (st == TAP_CAP_IR) sr = {22'h0, ins};
        if (st == TAP_CAP_IR) len = 10;
        if (st == TAP_CAP_DR) capDr();
        if (st == TAP_SHIFT_IR || st == TAP_SHIFT_DR) begin
            sr = sr >> 1;
            sr[len-1] = d;
        end
        if (st == TAP_UPD_IR) ins = sr[9:0];
        if (st == TAP_UPD_DR && (ins == BST_OP_SAMPLE || ins == BST_OP_EXTEST)) upd = sr[11:0];
        st = nxt(st, m);
        if (st == TAP_RESET) ins = BST_OP_IDCODE;
        sh = (st == TAP_SHIFT_IR || st == TAP_SHIFT_DR);
        cmpBit(oeN, !sh);
        if (sh) cmpBit(o, sr[0]);
    endtask : tc

    task automatic chkPins();
        repeat (8) @(negedge clk);
        cmpPins({pinOut & ~pinOeN, pinOeN}, expPins());
    endtask : chkPins

    // Starts and ends in run-test/idle; pz detours through the pause state
    task automatic scan(input bit ir, input logic [39:0] d, input int n, input bit ab,
            input bit pz);
        tc(1'b1, rb());
        if (ir) tc(1'b1, rb());
        tc(1'b0, rb());
        tc(1'b0, rb());
        for (int j = 0; j < n; j++) begin
            if (ab && j == 4) begin
                repeat (5) tc(1'b1, rb());
                tc(1'b1, rb());
                tc(1'b0, rb());
                bst_tester_inst.rest();
                return;
            end
            tc(j == n - 1, d[j]);
        end
        if (pz) begin
            tc(1'b0, rb());
            tc(1'b0, rb());
            tc(1'b1, rb());
        end
        tc(1'b1, rb());
        tc(1'b0, rb());
        tc(1'b0, rb());
        bst_tester_inst.rest();
    endtask : scan

    task automatic closeOut();
        if (badCount == 0 && cmpCount > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : closeOut

    initial begin
        nrst = 1'b0;
        gOe = 1'b1;
        coreIn = '0;
        userCode = 32'h0;
        extPin = 4'h0;
        lfsr = 32'h51a6d35d;
        st = TAP_RESET;
        ins = BST_OP_IDCODE;
        upd = '0;
        sr = '0;
        len = 1;
        badCount = 0;
        cmpCount = 0;
        repeat (8) @(negedge clk);
        tc(1'b1, 1'b1);
        tc(1'b1, 1'b1);
        cmpPins({pinOut, pinOeN}, 8'h0f);
        @(negedge clk);
        nrst = 1'b1;
        repeat (3) tc(1'b1, rb());
        tc(1'b0, rb());
        chkPins();
        for (int r = 0; r < 2; r++) begin
            for (int k = 0; k < 8; k++) begin
                @(negedge clk);
                gOe = (r == 0);
                void'(rb());
                coreIn = lfsr[7:0];
                extPin = lfsr[11:8];
                userCode = lfsr ^ 32'h3c96_a5e1;
                scan(1'b1, {30'h0, OPS[k]}, 10, r == 1 && k == 2, 1'b0);
                chkPins();
                for (int j = 0; j < 40; j++) v[j] = rb();
                scan(1'b0, v, 40, 1'b0, r == 1);
                chkPins();
            end
        end
        closeOut();
    end
endmodule : boundary_scan_tap_control_tb
